// File: hdl/gate_drive_pkg.sv
// Shared constants and types for the gate drive sequencer
package gate_drive_pkg;
	// Clock rate and timer step sizes
	localparam int CLK_MHZ = 100;
	localparam int DRV_STEP_NS = 500;
	localparam int DEAD_STEP_NS = 100;
	localparam int BLK_STEP_NS = 1000;
	localparam int DRV_STEP_CYC = (DRV_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int DEAD_STEP_CYC = (DEAD_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int BLK_STEP_CYC = (BLK_STEP_NS * CLK_MHZ + 999) / 1000;

	// Register offsets
	localparam logic [3:0] ADDR_CODE0 = 4'h0;
	localparam logic [3:0] ADDR_CODE1 = 4'h1;
	localparam logic [3:0] ADDR_TIME0 = 4'h2;
	localparam logic [3:0] ADDR_TIME1 = 4'h3;
	localparam logic [3:0] ADDR_AMP = 4'h4;
	localparam logic [3:0] ADDR_CTRL = 4'h5;
	localparam logic [3:0] ADDR_STATUS = 4'h6;

	// Field positions
	localparam int CODE_SRC_LSB = 0;
	localparam int CODE_SNK_LSB = 4;
	localparam int TIME_DRV_LSB = 0;
	localparam int TIME_DEAD_LSB = 3;
	localparam int AMP_GAIN_LSB = 0;
	localparam int AMP_DIV_BIT = 2;
	localparam int AMP_BSEL_BIT = 3;
	localparam int AMP_BLK_LSB = 4;
	localparam int AMP_BEN_BIT = 6;
	localparam int AMP_SH_BIT = 7;
	localparam int CTRL_HIZ_LSB = 0;
	localparam int ST_UV_BIT = 4;
	localparam int ST_UV_LIVE_BIT = 5;

	// Reset values
	localparam logic [7:0] CODE_RST = 8'h88;
	localparam logic [7:0] TIME_RST = 8'h03;
	localparam logic [7:0] AMP_RST = 8'h04;
	localparam logic [7:0] CTRL_RST = 8'h03;
	localparam logic REF_DIV_HALF = 1'b1;

	// Drive code for each level of the six-level select pin
	localparam logic [3:0] PIN_CODE [0:5] = '{4'h0, 4'h2, 4'h5, 4'h8,
		4'hb, 4'hf};

	typedef enum logic [2:0] {
		S_OFF = 3'h0,
		S_BREAK = 3'h1,
		S_DEAD = 3'h3,
		S_DRIVE = 3'h2,
		S_HOLD = 3'h6
	} gate_seq_state_t;

	typedef enum logic [1:0] {
		STG_STRONG = 2'h0,
		STG_SINK = 2'h1,
		STG_SOURCE = 2'h2,
		STG_HOLD = 2'h3
	} drive_stage_t;
endpackage

// File: hdl/hb_if.sv
// Link between the top controller and one half-bridge sequencer
`timescale 1ns/1ps
interface hb_if import gate_drive_pkg::*;;
	logic [1:0] cmd;
	logic vgs_hs;
	logic vgs_ls;
	logic [2:0] drv_sel;
	logic [2:0] dead_sel;
	logic gh;
	logic gl;
	drive_stage_t stg_h;
	drive_stage_t stg_l;
	logic flt_h;
	logic flt_l;
	modport ctrl (output cmd, vgs_hs, vgs_ls, drv_sel, dead_sel,
		input gh, gl, stg_h, stg_l, flt_h, flt_l);
	modport seq (input cmd, vgs_hs, vgs_ls, drv_sel, dead_sel,
		output gh, gl, stg_h, stg_l, flt_h, flt_l);
endinterface

// File: hdl/half_bridge_seq.sv
// Break-before-make and drive pulse sequencer for one half-bridge
`timescale 1ns/1ps
module half_bridge_seq import gate_drive_pkg::*; (
	input wire logic mclk,
	input wire logic resetn,
	hb_if.seq hb
);
	gate_seq_state_t state_reg;
	logic [1:0] cmd_prev_reg;
	logic [1:0] tgt_reg;
	logic [11:0] cnt_reg;
	logic flt_h_reg;
	logic flt_l_reg;
	logic cmd_new;
	logic [11:0] drv_cyc;
	logic [11:0] dead_cyc;

	// Timer lengths from the per-bridge settings
	assign cmd_new = hb.cmd != cmd_prev_reg;
	assign drv_cyc = 12'((12'(hb.drv_sel) + 12'h001) * 12'(DRV_STEP_CYC));
	assign dead_cyc = 12'(12'(hb.dead_sel) * 12'(DEAD_STEP_CYC));

	// Sequencer; any new command restarts it, cutting a pulse short
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= S_OFF;
			cmd_prev_reg <= 2'h0;
			tgt_reg <= 2'h0;
			cnt_reg <= 12'h000;
		end
		else
		begin
			cmd_prev_reg <= hb.cmd;
			if (cmd_new)
			begin
				state_reg <= S_BREAK;
				tgt_reg <= hb.cmd;
				cnt_reg <= drv_cyc;
			end
			else
			begin
				case (state_reg)
					S_BREAK:
					begin
						if (cnt_reg != 12'h000)
							cnt_reg <= cnt_reg - 12'h001;
						// Wait for both gates to read off
						if (!hb.vgs_hs && !hb.vgs_ls)
						begin
							if (tgt_reg == 2'h0 || tgt_reg == 2'h3)
								state_reg <= S_OFF;
							else if (dead_cyc != 12'h000)
							begin
								state_reg <= S_DEAD;
								cnt_reg <= dead_cyc;
							end
							else
							begin
								state_reg <= S_DRIVE;
								cnt_reg <= drv_cyc;
							end
						end
					end
					S_DEAD:
					begin
						cnt_reg <= cnt_reg - 12'h001;
						if (cnt_reg == 12'h001)
						begin
							state_reg <= S_DRIVE;
							cnt_reg <= drv_cyc;
						end
					end
					S_DRIVE:
					begin
						cnt_reg <= cnt_reg - 12'h001;
						if (cnt_reg == 12'h001)
							state_reg <= S_HOLD;
					end
					default:
						state_reg <= state_reg;
				endcase
			end
		end
	end

	// Gate check at the end of each drive pulse and of the break timer, one-cycle events
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			flt_h_reg <= 1'b0;
			flt_l_reg <= 1'b0;
		end
		else
		begin
			flt_h_reg <= !cmd_new && cnt_reg == 12'h001 &&
				((state_reg == S_DRIVE && tgt_reg[1] && !hb.vgs_hs) ||
				(state_reg == S_BREAK && hb.vgs_hs));
			flt_l_reg <= !cmd_new && cnt_reg == 12'h001 &&
				((state_reg == S_DRIVE && tgt_reg[0] && !hb.vgs_ls) ||
				(state_reg == S_BREAK && hb.vgs_ls));
		end
	end

	// Gate enables and current stage; an off gate is sunk in the break wait while it reads on and the break timer runs, else held strongly
	assign hb.gh = (state_reg == S_DRIVE || state_reg == S_HOLD) && tgt_reg[1];
	assign hb.gl = (state_reg == S_DRIVE || state_reg == S_HOLD) && tgt_reg[0];
	assign hb.stg_h = hb.gh ? (state_reg == S_DRIVE ? STG_SOURCE : STG_HOLD) :
		(state_reg == S_BREAK && cnt_reg != 12'h000 && hb.vgs_hs) ?
		STG_SINK : STG_STRONG;
	assign hb.stg_l = hb.gl ? (state_reg == S_DRIVE ? STG_SOURCE : STG_HOLD) :
		(state_reg == S_BREAK && cnt_reg != 12'h000 && hb.vgs_ls) ?
		STG_SINK : STG_STRONG;
	assign hb.flt_h = flt_h_reg;
	assign hb.flt_l = flt_l_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_pulse_end;
		state_reg == S_DRIVE && cnt_reg == 12'h001 && !cmd_new;
	endsequence

	a_pulse_to_hold: assert property (s_pulse_end |=> state_reg == S_HOLD)
		else $error("drive pulse did not fall back to hold");
	a_cmd_restart: assert property (cmd_new |=> state_reg == S_BREAK
		&& cnt_reg == $past(drv_cyc))
		else $error("new command did not restart sequencer");
	a_end_fault: assert property ((s_pulse_end ##0 (tgt_reg[1] &&
		!hb.vgs_hs)) |=> flt_h_reg ##1 !flt_h_reg)
		else $error("missing one-cycle gate fault at pulse end");
endmodule

// File: hdl/gate_drive_ctrl.sv
// Gate drive controller: registers, two sequencers, amplifier control
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module gate_drive_ctrl import gate_drive_pkg::*; #(
	parameter bit HW_VARIANT = 1'b0
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] pwm_in,
	input wire logic [1:0] vgs_hs_mon,
	input wire logic [1:0] vgs_ls_mon,
	input wire logic cp_uv_mon,
	input wire logic [2:0] drive_current_select_pin,
	input wire logic [1:0] amp_gain_pin,
	output logic [1:0] high_side_gate_out,
	output logic [1:0] low_side_gate_out,
	output logic [3:0] high_stage,
	output logic [3:0] low_stage,
	output logic [7:0] gate_source_current_code,
	output logic [7:0] gate_sink_current_code,
	output logic [1:0] amp_scale_setting,
	output logic ref_divide_setting,
	output logic amp_out_connect,
	output logic fault_n
);
	logic [7:0] code_reg [2];
	logic [7:0] time_reg [2];
	logic [7:0] amp_reg;
	logic [7:0] ctrl_reg;
	logic [5:0] status_reg;
	logic [7:0] rdata_reg;
	logic fault_n_reg;
	logic [1:0] scale_reg;
	logic div_reg;
	logic connect_reg;
	logic [11:0] blank_cnt_reg;
	logic [3:0] flt_evt;
	logic [1:0] nxt_gh;
	logic [1:0] nxt_gl;
	logic [1:0] edge_evt;
	logic [3:0] pin_code;
	logic [4:0] st_clr;
	logic edge_sel;
	logic blank_active;
	logic brake;
	logic blank_en;
	logic sh_en;
	logic [11:0] blank_cyc;

	// Out-of-range pin levels clamp to the top setting
	assign pin_code = PIN_CODE[(drive_current_select_pin > 3'h5) ?
		3'h5 : drive_current_select_pin];

	// Register writes; status is handled with its own flags below
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			code_reg[0] <= CODE_RST;
			code_reg[1] <= CODE_RST;
			time_reg[0] <= TIME_RST;
			time_reg[1] <= TIME_RST;
			amp_reg <= AMP_RST;
			ctrl_reg <= CTRL_RST;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				ADDR_CODE0: code_reg[0] <= reg_wdata;
				ADDR_CODE1: code_reg[1] <= reg_wdata;
				ADDR_TIME0: time_reg[0] <= reg_wdata;
				ADDR_TIME1: time_reg[1] <= reg_wdata;
				ADDR_AMP: amp_reg <= reg_wdata;
				ADDR_CTRL: ctrl_reg <= reg_wdata;
				default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			rdata_reg <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				ADDR_CODE0: rdata_reg <= code_reg[0];
				ADDR_CODE1: rdata_reg <= code_reg[1];
				ADDR_TIME0: rdata_reg <= time_reg[0];
				ADDR_TIME1: rdata_reg <= time_reg[1];
				ADDR_AMP: rdata_reg <= amp_reg;
				ADDR_CTRL: rdata_reg <= ctrl_reg;
				ADDR_STATUS: rdata_reg <= {2'h0, status_reg};
				default: rdata_reg <= 8'h00;
			endcase
		end
		else
			rdata_reg <= 8'h00;
	end
	assign reg_rdata = rdata_reg;

	// Write one to clear; a same-cycle event still sets the flag
	assign st_clr = (reg_wr && reg_addr == ADDR_STATUS) ? reg_wdata[4:0] :
		5'h00;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			status_reg <= 6'h00;
			fault_n_reg <= 1'b1;
		end
		else
		begin
			status_reg[4:0] <= (status_reg[4:0] & ~st_clr) |
				{cp_uv_mon, flt_evt};
			status_reg[ST_UV_LIVE_BIT] <= cp_uv_mon;
			fault_n_reg <= ~(|status_reg[4:0]);
		end
	end
	assign fault_n = fault_n_reg;

	// One sequencer per half-bridge
	for (genvar g = 0; g < 2; g++)
	begin : gen_hb
		hb_if hbi ();
		logic gh_reg;
		logic gl_reg;
		drive_stage_t sh_reg;
		drive_stage_t sl_reg;
		logic [3:0] src_reg;
		logic [3:0] snk_reg;

		half_bridge_seq u_seq (
			.mclk(mclk),
			.resetn(resetn),
			.hb(hbi)
		);

		// Hi-Z or charge pump undervoltage leaves both gates off
		assign hbi.cmd = (ctrl_reg[CTRL_HIZ_LSB + g] ||
			status_reg[ST_UV_LIVE_BIT]) ? 2'h0 :
			(pwm_in[g] ? 2'h2 : 2'h1);
		assign hbi.vgs_hs = vgs_hs_mon[g];
		assign hbi.vgs_ls = vgs_ls_mon[g];
		assign hbi.drv_sel = time_reg[g][TIME_DRV_LSB +: 3];
		assign hbi.dead_sel = time_reg[g][TIME_DEAD_LSB +: 3];

		// Registered gate outputs and current stages
		always_ff @(posedge mclk or negedge resetn)
		begin
			if (!resetn)
			begin
				gh_reg <= 1'b0;
				gl_reg <= 1'b0;
				sh_reg <= STG_STRONG;
				sl_reg <= STG_STRONG;
			end
			else
			begin
				gh_reg <= hbi.gh;
				gl_reg <= hbi.gl;
				sh_reg <= hbi.stg_h;
				sl_reg <= hbi.stg_l;
			end
		end

		// Codes follow the source live, so changes apply mid-run
		always_ff @(posedge mclk or negedge resetn)
		begin
			if (!resetn)
			begin
				src_reg <= CODE_RST[CODE_SRC_LSB +: 4];
				snk_reg <= CODE_RST[CODE_SNK_LSB +: 4];
			end
			else
			begin
				src_reg <= HW_VARIANT ? pin_code :
					code_reg[g][CODE_SRC_LSB +: 4];
				snk_reg <= HW_VARIANT ? pin_code :
					code_reg[g][CODE_SNK_LSB +: 4];
			end
		end

		assign high_side_gate_out[g] = gh_reg;
		assign low_side_gate_out[g] = gl_reg;
		assign high_stage[2 * g +: 2] = sh_reg;
		assign low_stage[2 * g +: 2] = sl_reg;
		assign gate_source_current_code[4 * g +: 4] = src_reg;
		assign gate_sink_current_code[4 * g +: 4] = snk_reg;
		assign flt_evt[2 * g] = hbi.flt_h;
		assign flt_evt[2 * g + 1] = hbi.flt_l;
		assign nxt_gh[g] = hbi.gh;
		assign nxt_gl[g] = hbi.gl;
		assign edge_evt[g] = (hbi.gh != gh_reg) || (hbi.gl != gl_reg);
	end

	// Blanking and sample-hold are absent on pin-strapped parts
	assign blank_en = !HW_VARIANT && amp_reg[AMP_BEN_BIT];
	assign sh_en = !HW_VARIANT && amp_reg[AMP_SH_BIT];
	assign edge_sel = edge_evt[amp_reg[AMP_BSEL_BIT]];
	assign blank_cyc = 12'((12'(amp_reg[AMP_BLK_LSB +: 2]) + 12'h001) *
		12'(BLK_STEP_CYC) - 12'h001);
	assign blank_active = edge_sel || blank_cnt_reg != 12'h000;
	// Both lows or both highs on means the load is recirculating
	assign brake = (&nxt_gl) || (&nxt_gh);

	// Blanking window; edge compare sees the gate change a cycle early
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			blank_cnt_reg <= 12'h000;
		else if (edge_sel)
			blank_cnt_reg <= blank_cyc;
		else if (blank_cnt_reg != 12'h000)
			blank_cnt_reg <= blank_cnt_reg - 12'h001;
	end

	// Output switch; the hold capacitor keeps the last value outside
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			connect_reg <= 1'b1;
		else
			connect_reg <= !((blank_en && blank_active) ||
				(sh_en && brake));
	end
	assign amp_out_connect = connect_reg;

	// Gain stage select and reference divider
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			scale_reg <= AMP_RST[AMP_GAIN_LSB +: 2];
			div_reg <= AMP_RST[AMP_DIV_BIT];
		end
		else
		begin
			// Code n picks stage gain 5 shl n, total twice that
			scale_reg <= HW_VARIANT ? amp_gain_pin :
				amp_reg[AMP_GAIN_LSB +: 2];
			div_reg <= HW_VARIANT ? REF_DIV_HALF : amp_reg[AMP_DIV_BIT];
		end
	end
	assign amp_scale_setting = scale_reg;
	assign ref_divide_setting = div_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_sel_edge;
		blank_en && edge_sel;
	endsequence

	a_fault_sticky: assert property ((|flt_evt) |=>
		((status_reg[3:0] & $past(flt_evt)) == $past(flt_evt)))
		else $error("gate fault event not latched");
	a_fault_pin: assert property ((|flt_evt) |=> ##1 !fault_n)
		else $error("fault output not asserted after gate fault");
	a_uv_watch: assert property (cp_uv_mon |=> status_reg[ST_UV_BIT]
		&& status_reg[ST_UV_LIVE_BIT])
		else $error("charge pump undervoltage missed");
	a_blank_cut: assert property (s_sel_edge |=> !amp_out_connect ##1
		!amp_out_connect)
		else $error("amp not blanked after selected gate edge");
	a_hold_brake: assert property ((sh_en && brake) |=>
		!amp_out_connect)
		else $error("amp not held during braking");
	a_reconnect: assert property ((!blank_active && !brake) |=>
		amp_out_connect)
		else $error("amp not reconnected");
	a_no_overlap: assert property (!(high_side_gate_out[0] &&
		low_side_gate_out[0]) && !(high_side_gate_out[1] &&
		low_side_gate_out[1]))
		else $error("both gates of one bridge on");
	a_break_make: assert property ((time_reg[0][TIME_DEAD_LSB +: 3] == 3'h0
		&& $rose(high_side_gate_out[0])) |-> !$past(vgs_ls_mon[0], 2))
		else $error("high side on before low side read off");
	a_strong_off: assert property ((low_stage[1:0] == STG_SOURCE) |->
		high_stage[1:0] == STG_STRONG)
		else $error("off gate not held by strong pulldown");
	a_code_live: assert property ((!HW_VARIANT && reg_wr &&
		reg_addr == ADDR_CODE0) |=> ##1
		gate_source_current_code[3:0] == $past(reg_wdata[3:0], 2))
		else $error("source code write not applied");
endmodule

// File: bench/fet_model.sv
// Behavioural model of the external power switches of both half-bridges
`timescale 1ns/1ps
module fet_model #(
	parameter int FAST_CYC = 4,
	parameter int SLOW_CYC = 40
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [1:0] gh,
	input wire logic [1:0] gl,
	input wire logic [1:0] stuck_h,
	input wire logic slow,
	output logic [1:0] vgs_hs,
	output logic [1:0] vgs_ls
);
	int cnt_h [2];
	int cnt_l [2];
	int lag;
	assign lag = slow ? SLOW_CYC : FAST_CYC;

	// Gate voltage trails its enable by the charge time; a stuck gate stays low
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			vgs_hs <= 2'h0;
			vgs_ls <= 2'h0;
			cnt_h <= '{0, 0};
			cnt_l <= '{0, 0};
		end
		else
		begin
			for (int g = 0; g < 2; g++)
			begin
				if ((gh[g] & ~stuck_h[g]) == vgs_hs[g])
					cnt_h[g] <= 0;
				else if (cnt_h[g] >= lag - 1)
					vgs_hs[g] <= gh[g] & ~stuck_h[g];
				else
					cnt_h[g] <= cnt_h[g] + 1;
				if (gl[g] == vgs_ls[g])
					cnt_l[g] <= 0;
				else if (cnt_l[g] >= lag - 1)
					vgs_ls[g] <= gl[g];
				else
					cnt_l[g] <= cnt_l[g] + 1;
			end
		end
	end
endmodule

// File: bench/tb.sv
// Self-checking bench for the gate drive controller
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			n_fail++; \
			$display("CHECK FAILED t=%0t %s", $time, msg); \
		end \
	end
module tb import gate_drive_pkg::*;;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [1:0] pwm_in = 2'h0;
	logic [1:0] vgs_hs_mon, vgs_ls_mon, hs, ls, stuck_h = 2'h0, scale;
	logic cp_uv_mon = 1'b0;
	logic slow = 1'b0;
	logic [3:0] high_stage, low_stage;
	logic [7:0] src_code, snk_code;
	logic rdiv, amp_conn, fault_n;
	int n_fail = 0;
	int samples_checked = 0;
	int i, drv, dead, code;
	int unsigned seed_val;
	logic [3:0] snk;
	logic [2:0] drv_pin = 3'h0;
	logic [1:0] gain_pin = 2'h0;
	logic [7:0] hw_src, hw_snk;
	logic [1:0] hw_scale;
	logic hw_rdiv, hw_conn;

	gate_drive_ctrl i_dut (.mclk(mclk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_in(pwm_in),
		.vgs_hs_mon(vgs_hs_mon), .vgs_ls_mon(vgs_ls_mon),
		.cp_uv_mon(cp_uv_mon), .drive_current_select_pin(drv_pin),
		.amp_gain_pin(gain_pin), .high_side_gate_out(hs),
		.low_side_gate_out(ls), .high_stage(high_stage),
		.low_stage(low_stage), .gate_source_current_code(src_code),
		.gate_sink_current_code(snk_code), .amp_scale_setting(scale),
		.ref_divide_setting(rdiv), .amp_out_connect(amp_conn),
		.fault_n(fault_n));
	// Pin-strapped twin on the same bus; its gates are left unwatched
	gate_drive_ctrl #(.HW_VARIANT(1'b1)) i_dut_hw (.mclk(mclk),
		.resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .pwm_in(pwm_in),
		.vgs_hs_mon(2'h0), .vgs_ls_mon(2'h0), .cp_uv_mon(cp_uv_mon),
		.drive_current_select_pin(drv_pin), .amp_gain_pin(gain_pin),
		.high_side_gate_out(), .low_side_gate_out(), .high_stage(),
		.low_stage(), .gate_source_current_code(hw_src),
		.gate_sink_current_code(hw_snk), .amp_scale_setting(hw_scale),
		.ref_divide_setting(hw_rdiv), .amp_out_connect(hw_conn),
		.fault_n());
	fet_model i_fet (.mclk(mclk), .resetn(resetn), .gh(hs), .gl(ls),
		.stuck_h(stuck_h), .slow(slow), .vgs_hs(vgs_hs_mon),
		.vgs_ls(vgs_ls_mon));

	// 100 MHz clock
	always #5 mclk = ~mclk;

	task automatic final_report;
		if (n_fail == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] e,
		input logic [7:0] m);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata & m, e & m, "register read")
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	function automatic logic [1:0] stg(input int g, input logic hi);
		return hi ? high_stage[2 * g +: 2] : low_stage[2 * g +: 2];
	endfunction

	function automatic logic gate(input int g, input logic hi);
		return hi ? hs[g] : ls[g];
	endfunction

	// One commanded transition of bridge g towards side v, timed end to end
	task automatic sw(input int g, input logic v, input int dr, input int de);
		int n;
		int t;
		@(posedge mclk);
		pwm_in[g] <= v;
		n = 0;
		do
		begin
			tick(1);
			n++;
		end
		while ((v ? vgs_ls_mon[g] : vgs_hs_mon[g]) !== 1'b0 && n < 500);
		`CHK(stg(g, v), STG_STRONG, "incoming stage not strong")
		t = 0;
		do
		begin
			tick(1);
			t++;
		end
		while (gate(g, v) !== 1'b1 && t < 500);
		`CHK(gate(g, !v), 1'b0, "both gates on")
		t = t - 3 - de * DEAD_STEP_CYC;
		`CHK(t >= -1 && t <= 1, 1'b1, "dead time")
		`CHK(stg(g, !v), STG_STRONG, "off stage not strong")
		n = 0;
		while (stg(g, v) === STG_SOURCE && n < 1000)
		begin
			tick(1);
			n++;
		end
		n = n - (dr + 1) * DRV_STEP_CYC;
		`CHK(n >= -2 && n <= 2, 1'b1, "drive pulse length")
		`CHK(stg(g, v), STG_HOLD, "no hold current")
	endtask

	// Toggle bridge g and time the output cut after its last gate edge
	task automatic blank_run(input int sel, input int c, input int g);
		int k;
		int n;
		logic [1:0] prev;
		wr(ADDR_AMP, {2'b01, c[1:0], sel[0], 3'b100});
		@(posedge mclk);
		pwm_in[g] <= ~pwm_in[g];
		prev = {hs[g], ls[g]};
		k = 0;
		n = 0;
		repeat (600)
		begin
			tick(1);
			if ({hs[g], ls[g]} !== prev)
			begin
				prev = {hs[g], ls[g]};
				k = 0;
				n++;
				if (n == 1)
				begin
					`CHK(amp_conn, sel != g, "cut at gate edge")
					`CHK(hw_conn, 1'b1, "pin part blanked")
				end
			end
			else if (amp_conn === 1'b0)
				k++;
		end
		k = (sel == g) ? k - (c + 1) * BLK_STEP_CYC : k;
		`CHK(k >= -2 && k <= 2, 1'b1, "blank period")
	endtask

	// Hang guard, far beyond the expected run length
	initial
	begin
		#900000;
		n_fail++;
		final_report();
	end

	initial
	begin
		seed_val = $urandom(32'hb2fd);
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		tick(1);
		`CHK({hs, ls, fault_n, amp_conn, rdiv}, 7'h07, "reset outputs")
		`CHK({src_code, snk_code}, 16'h8888, "reset codes")
		rd(ADDR_CODE0, CODE_RST, 8'hff);
		rd(ADDR_CODE1, CODE_RST, 8'hff);
		rd(ADDR_TIME1, TIME_RST, 8'hff);
		rd(ADDR_AMP, AMP_RST, 8'hff);
		rd(ADDR_CTRL, CTRL_RST, 8'hff);
		wr(4'hd, 8'h5a);
		rd(4'hd, 8'h00, 8'hff);
		// Every current code on source, random sink, alternate bridges
		for (i = 0; i < 16; i++)
		begin
			snk = 4'($urandom());
			wr(4'(i % 2), {snk, 4'(i)});
			tick(2);
			`CHK(src_code[4 * (i % 2) +: 4], 4'(i), "source code")
			`CHK(snk_code[4 * (i % 2) +: 4], snk, "sink code")
		end
		for (i = 0; i < 4; i++)
		begin
			code = $urandom_range(1, 0);
			wr(ADDR_AMP, {5'h00, code[0], 2'(i)});
			tick(2);
			`CHK({scale, rdiv}, {2'(i), code[0]}, "gain and divider")
			rd(ADDR_AMP, {5'h00, code[0], 2'(i)}, 8'hff);
		end
		// Every pin level on the strapped part, clamped above five
		for (i = 0; i < 8; i++)
		begin
			@(posedge mclk);
			drv_pin <= 3'(i);
			gain_pin <= 2'(i);
			tick(3);
			`CHK({hw_src[3:0], hw_snk[7:4]}, {2{PIN_CODE[(i > 5) ? 5 : i]}}, "pin code")
			`CHK({hw_scale, hw_rdiv}, {2'(i), REF_DIV_HALF}, "pin gain")
		end
		wr(ADDR_CTRL, 8'h00);
		tick(600);
		// Drive times kept above the model's charge time
		for (i = 0; i < 4; i++)
		begin
			drv = $urandom_range(7, 0);
			dead = (i == 0) ? 0 : $urandom_range(7, 1);
			slow <= i[1];
			wr(4'(ADDR_TIME0 + i % 2), 8'((dead << 3) | drv));
			sw(i % 2, 1'b1, drv, dead);
			sw(i % 2, 1'b0, drv, dead);
		end
		slow <= 1'b0;
		tick(600);
		// Command during the pulse cuts it short without a false fault
		@(posedge mclk);
		pwm_in[0] <= 1'b1;
		i = 0;
		while (hs[0] !== 1'b1 && i < 500)
		begin
			tick(1);
			i++;
		end
		tick(10);
		pwm_in[0] <= 1'b0;
		tick(4);
		`CHK(hs[0], 1'b0, "pulse not cut")
		tick(600);
		`CHK(fault_n, 1'b1, "false fault")
		rd(ADDR_STATUS, 8'h00, 8'h0f);
		// High gate of bridge 1 never charges
		stuck_h <= 2'h2;
		wr(ADDR_TIME1, 8'h00);
		sw(1, 1'b1, 0, 0);
		tick(4);
		`CHK(fault_n, 1'b0, "fault output")
		rd(ADDR_STATUS, 8'h04, 8'h0f);
		wr(ADDR_STATUS, 8'h04);
		stuck_h <= 2'h0;
		rd(ADDR_STATUS, 8'h00, 8'h0f);
		tick(100);
		for (i = 0; i < 4; i++)
			blank_run(i / 2, $urandom_range(3, 0), i % 2);
		tick(600);
		wr(ADDR_AMP, 8'h84);
		for (i = 0; i < 2; i++)
		begin
			@(posedge mclk);
			pwm_in <= {2{i[0]}};
			tick(100);
			`CHK(amp_conn, 1'b0, "not held in braking")
			`CHK(hw_conn, 1'b1, "pin part held")
			pwm_in[0] <= ~i[0];
			tick(100);
			`CHK(amp_conn, 1'b1, "not reconnected")
		end
		@(posedge mclk);
		cp_uv_mon <= 1'b1;
		tick(10);
		`CHK({hs, ls}, 4'h0, "gates on in undervoltage")
		rd(ADDR_STATUS, 8'h30, 8'h30);
		cp_uv_mon <= 1'b0;
		tick(5);
		rd(ADDR_STATUS, 8'h10, 8'h30);
		wr(ADDR_STATUS, 8'h10);
		rd(ADDR_STATUS, 8'h00, 8'h30);
		final_report();
	end
endmodule
